// File: verilog/dram_cmd_pkg.sv
// Shared constants and types for the DRAM command decoder
package dram_cmd_pkg;
  // Array geometry
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int MR_W   = 14;
  localparam int NMR    = 4;
  localparam int SYNC_W = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_BANKS   = 8'h08;
  localparam logic [7:0] OFS_MODE0   = 8'h0c;
  localparam logic [7:0] OFS_LAT     = 8'h10;
  localparam logic [7:0] OFS_LASTACT = 8'h14;

  // Register fields and reset values
  localparam int CTRL_TERM_BIT    = 0;
  localparam int ST_SUSP_BIT      = 0;
  localparam int ST_PD_BIT        = 1;
  localparam int ST_BUSY_BIT      = 2;
  localparam int ST_OVL_BIT       = 3;
  localparam int LAT_WLAT_LO      = 8;
  localparam int LASTACT_BANK_LO  = 16;
  localparam logic CTRL_TERM_RST  = 1'b0;
  localparam logic [MR_W-1:0] MR_RST = 14'h0000;

  // Mode register field positions
  localparam int MODE0_BL_LO     = 0;
  localparam int MODE0_ORDER_BIT = 3;
  localparam int MODE0_CAS_LO    = 4;
  localparam int MODE0_PDX_BIT   = 12;
  localparam int MODE1_ADD_LO    = 3;
  localparam int MODE2_WCAS_LO   = 3;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_PERCMD = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Latency arithmetic
  localparam logic [4:0] CAS_MIN   = 5'h05;
  localparam logic [4:0] CAS_BASE  = 5'h04;
  localparam logic [4:0] WCAS_BASE = 5'h05;
  localparam logic [4:0] WCAS_MAX  = 5'h08;
  localparam logic [2:0] WCAS_TOP  = 3'h3;
  localparam logic [2:0] LAST8     = 3'h7;
  localparam logic [2:0] LAST4     = 3'h3;

  // Enabled cycles after reset before the compare stage holds real pin samples
  localparam logic [1:0] WARM_DONE = 2'h3;

  // Decoded commands
  typedef enum logic [2:0] {
    CMD_NOP  = 3'b000,
    CMD_ACT  = 3'b001,
    CMD_PRE  = 3'b010,
    CMD_RD   = 3'b011,
    CMD_WR   = 3'b100,
    CMD_MODE = 3'b101,
    CMD_REF  = 3'b110,
    CMD_NONE = 3'b111
  } cmd_t;

  // Burst engine states
  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_WAIT = 2'b01,
    B_BEAT = 2'b10
  } bst_t;
endpackage : dram_cmd_pkg

// File: verilog/sync_two.sv
// Two-flop synchroniser for a vector of slow pins
`timescale 1ns/100ps
module sync_two #(
  parameter int W = 1
) (
  // Clocking
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else if (en_i)
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sync_two

// File: verilog/dram_cmd_decoder.sv
// Command decoder, bank tracker and burst timing engine of a DDR DRAM
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
module dram_cmd_decoder
  import dram_cmd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               REF_CLK_I,
  input  wire logic               RST_I,
  input  wire logic               CLK_EN_I,
  // Memory link pins
  input  wire logic               LINK_CLK_I,
  input  wire logic               LINK_CLK_N_I,
  input  wire logic               CLOCK_GATE_I,
  input  wire logic               CHIP_SEL_N_I,
  input  wire logic               ROW_STROBE_N_I,
  input  wire logic               COL_STROBE_N_I,
  input  wire logic               WRITE_SEL_N_I,
  input  wire logic [BANK_W-1:0]  BANK_SEL_I,
  input  wire logic [ROW_W-1:0]   ADDR_I,
  // Burst, strobe, termination and status outputs
  output logic                    RD_VALID_O,
  output logic                    WR_WINDOW_O,
  output logic [2:0]              BEAT_COL_O,
  output logic                    STROBE_O,
  output logic                    STROBE_OE_O,
  output logic                    WMASK_EN_O,
  output logic                    TERM_EN_O,
  output logic                    SUSPENDED_O,
  output logic                    PD_FAST_EXIT_O,
  output logic [NBANK-1:0]        BANK_OPEN_O,
  // Avalon-MM slave
  input  wire logic [7:0]         AVS_ADDRESS_I,
  input  wire logic               AVS_READ_I,
  input  wire logic               AVS_WRITE_I,
  input  wire logic [31:0]        AVS_WRITEDATA_I,
  input  wire logic [3:0]         AVS_BYTEENABLE_I,
  output logic [31:0]             AVS_READDATA_O,
  output logic                    AVS_WAITREQUEST_O
);
  logic [SYNC_W-1:0] sv;
  logic [SYNC_W-1:0] prev_q;
  logic              diff;
  logic              diff_prev;
  logic              rise;
  logic              fall;
  logic              go;
  logic              edge_en;
  cmd_t              cmd;
  logic              cmd_cke;
  logic              cmd_cs_n;
  logic [BANK_W-1:0] cmd_ba;
  logic [ROW_W-1:0]  cmd_addr;
  logic [NBANK-1:0]  bank_q;
  logic [NBANK-1:0]  bank_d;
  logic [MR_W-1:0]   mr_q [NMR];
  logic              susp_q;
  logic              pd_q;
  logic              term_q;
  logic              ovl_q;
  logic [ROW_W-1:0]  last_row_q;
  logic [BANK_W-1:0] last_bank_q;
  bst_t              bst_q;
  logic              acc_wr_q;
  logic              acc_ap_q;
  logic              acc_chop_q;
  logic [BANK_W-1:0] acc_bank_q;
  logic [2:0]        acc_col_q;
  logic [4:0]        lat_q;
  logic [2:0]        beat_q;
  logic              close_ap;
  logic [4:0]        cas_lat;
  logic [4:0]        add_lat;
  logic [4:0]        wcas_lat;
  logic [4:0]        rd_lat;
  logic [4:0]        wr_lat;
  logic              chop;
  logic              wait_q;
  logic              avs_req;
  logic [1:0]        warm_q;

  // Assertion clock and reset for the whole module
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  // Link pins cross into the reference clock domain together
  sync_two #(.W(SYNC_W)) u_sync (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .en_i  (CLK_EN_I),
    .d_i   ({LINK_CLK_I, LINK_CLK_N_I, CLOCK_GATE_I, CHIP_SEL_N_I, ROW_STROBE_N_I,
             COL_STROBE_N_I, WRITE_SEL_N_I, BANK_SEL_I, ADDR_I}),
    .q_o   (sv)
  );

  // Keep the sample before the crossing: it meets setup, the later one may not
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      prev_q <= '0;
    else if (CLK_EN_I)
      prev_q <= sv;
  end

  // Reset zeros look like chip select and gate low; no edge counts until real samples arrive
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      warm_q <= 2'h0;
    else if (CLK_EN_I && warm_q != WARM_DONE)
      warm_q <= warm_q + 2'h1;
  end

  // Crossing detection: true high with complement low
  assign diff      = sv[23] & ~sv[22];
  assign diff_prev = prev_q[23] & ~prev_q[22];
  assign rise      = diff & ~diff_prev & (warm_q == WARM_DONE);
  assign fall      = ~diff & diff_prev;
  assign go        = rise & ~susp_q;
  assign edge_en   = (rise | fall) & ~susp_q;

  // Command fields from the pre-crossing sample
  assign cmd_cke  = prev_q[21];
  assign cmd_cs_n = prev_q[20];
  assign cmd_ba   = prev_q[16:14];
  assign cmd_addr = prev_q[13:0];

  // Command decode
  always_comb
  begin
    cmd = CMD_NONE;
    if (!cmd_cs_n)
    begin
      case (prev_q[19:17])
        3'b111:  cmd = CMD_NOP;
        3'b011:  cmd = CMD_ACT;
        3'b010:  cmd = CMD_PRE;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b000:  cmd = CMD_MODE;
        3'b001:  cmd = CMD_REF;
        default: cmd = CMD_NONE;
      endcase
    end
  end

  // Latency arithmetic from the mode registers
  always_comb
  begin
    cas_lat = (mr_q[0][MODE0_CAS_LO +: 3] == 3'h0) ? CAS_MIN : CAS_BASE + {2'h0, mr_q[0][MODE0_CAS_LO +: 3]};
    case (mr_q[1][MODE1_ADD_LO +: 2])
      2'h1:    add_lat = cas_lat - 5'h01;
      2'h2:    add_lat = cas_lat - 5'h02;
      default: add_lat = 5'h00;
    endcase
    wcas_lat = (mr_q[2][MODE2_WCAS_LO +: 3] > WCAS_TOP) ? WCAS_MAX
                                                        : WCAS_BASE + {2'h0, mr_q[2][MODE2_WCAS_LO +: 3]};
    rd_lat   = add_lat + cas_lat;
    wr_lat   = add_lat + wcas_lat;
    case (mr_q[0][MODE0_BL_LO +: 2])
      BL_FIXED8: chop = 1'b0;
      BL_FIXED4: chop = 1'b1;
      BL_PERCMD: chop = ~cmd_addr[12];
      default:   chop = 1'b0;
    endcase
  end

  // Auto-close fires on the edge that ends the last beat
  assign close_ap = (bst_q == B_BEAT) & edge_en & acc_ap_q &
                    (beat_q == (acc_chop_q ? LAST4 : LAST8));

  // Next bank state: commands win over auto-close, which is applied first
  always_comb
  begin
    bank_d = bank_q;
    if (close_ap)
      bank_d[acc_bank_q] = 1'b0;
    if (go && cmd == CMD_ACT)
      bank_d[cmd_ba] = 1'b1;
    else if (go && cmd == CMD_PRE && cmd_addr[10])
      bank_d = '0;
    else if (go && cmd == CMD_PRE)
      bank_d[cmd_ba] = 1'b0;
  end

  // Bank tracker and last activated row
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      bank_q      <= '0;
      last_row_q  <= '0;
      last_bank_q <= '0;
    end
    else if (CLK_EN_I)
    begin
      bank_q <= bank_d;
      if (go && cmd == CMD_ACT)
      begin
        last_row_q  <= cmd_addr;
        last_bank_q <= cmd_ba;
      end
    end
  end

  // Mode registers; only the four low selects exist
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < NMR; i++)
        mr_q[i] <= MR_RST;
    end
    else if (CLK_EN_I && go && cmd == CMD_MODE && !cmd_ba[2])
      mr_q[cmd_ba[1:0]] <= cmd_addr;
  end

  // Clock gate: suspension starts after the sampling crossing
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      susp_q <= 1'b0;
      pd_q   <= 1'b0;
    end
    else if (CLK_EN_I && rise)
    begin
      susp_q <= ~cmd_cke;
      if (!cmd_cke && !susp_q)
        pd_q <= (bank_q == '0);
      else if (cmd_cke)
        pd_q <= 1'b0;
    end
  end

  // Burst engine; one access in flight, overlaps are dropped and flagged
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      bst_q      <= B_IDLE;
      acc_wr_q   <= 1'b0;
      acc_ap_q   <= 1'b0;
      acc_chop_q <= 1'b0;
      acc_bank_q <= '0;
      acc_col_q  <= '0;
      lat_q      <= '0;
      beat_q     <= '0;
    end
    else if (CLK_EN_I)
    begin
      case (bst_q)
        B_IDLE:
        begin
          if (go && (cmd == CMD_RD || cmd == CMD_WR))
          begin
            acc_wr_q   <= (cmd == CMD_WR);
            acc_ap_q   <= cmd_addr[10];
            acc_chop_q <= chop;
            acc_bank_q <= cmd_ba;
            acc_col_q  <= cmd_addr[2:0];
            lat_q      <= ((cmd == CMD_WR) ? wr_lat : rd_lat) - 5'h01;
            bst_q      <= B_WAIT;
          end
        end
        B_WAIT:
        begin
          if (go && lat_q == 5'h00)
          begin
            bst_q  <= B_BEAT;
            beat_q <= 3'h0;
          end
          else if (go)
            lat_q <= lat_q - 5'h01;
        end
        B_BEAT:
        begin
          if (edge_en && beat_q == (acc_chop_q ? LAST4 : LAST8))
            bst_q <= B_IDLE;
          else if (edge_en)
            beat_q <= beat_q + 3'h1;
        end
        default: bst_q <= B_IDLE;
      endcase
    end
  end

  // Pin-side outputs, all registered
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      RD_VALID_O     <= 1'b0;
      WR_WINDOW_O    <= 1'b0;
      BEAT_COL_O     <= '0;
      STROBE_O       <= 1'b0;
      STROBE_OE_O    <= 1'b0;
      WMASK_EN_O     <= 1'b0;
      TERM_EN_O      <= 1'b0;
      SUSPENDED_O    <= 1'b0;
      PD_FAST_EXIT_O <= 1'b0;
      BANK_OPEN_O    <= '0;
    end
    else if (CLK_EN_I)
    begin
      RD_VALID_O  <= (bst_q == B_BEAT) & ~acc_wr_q;
      WR_WINDOW_O <= (bst_q == B_BEAT) & acc_wr_q;
      if (mr_q[0][MODE0_ORDER_BIT])
        BEAT_COL_O <= acc_col_q ^ beat_q;
      else
        BEAT_COL_O <= {acc_col_q[2] ^ beat_q[2], acc_col_q[1:0] + beat_q[1:0]};
      // Strobe level flips per beat, so its edges coincide with data edges
      STROBE_O       <= (bst_q == B_BEAT) & ~acc_wr_q & ~beat_q[0];
      STROBE_OE_O    <= (bst_q == B_BEAT) & ~acc_wr_q;
      WMASK_EN_O     <= (bst_q == B_BEAT) & acc_wr_q & ~term_q;
      TERM_EN_O      <= term_q;
      SUSPENDED_O    <= susp_q;
      PD_FAST_EXIT_O <= mr_q[0][MODE0_PDX_BIT];
      BANK_OPEN_O    <= bank_q;
    end
  end

  // Avalon slave: one wait state, write commits at the accepting edge
  assign avs_req = AVS_READ_I | AVS_WRITE_I;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      wait_q         <= 1'b1;
      AVS_READDATA_O <= '0;
    end
    else if (CLK_EN_I)
    begin
      wait_q <= ~(avs_req & wait_q);
      if (AVS_READ_I && wait_q)
      begin
        case (AVS_ADDRESS_I)
          OFS_CTRL:    AVS_READDATA_O <= {31'h0, term_q};
          OFS_STATUS:  AVS_READDATA_O <= {28'h0, ovl_q, bst_q != B_IDLE, pd_q, susp_q};
          OFS_BANKS:   AVS_READDATA_O <= {24'h0, bank_q};
          OFS_MODE0:   AVS_READDATA_O <= {18'h0, mr_q[0]};
          OFS_LAT:     AVS_READDATA_O <= {19'h0, wr_lat, 3'h0, rd_lat};
          OFS_LASTACT: AVS_READDATA_O <= {13'h0, last_bank_q, 2'h0, last_row_q};
          default:     AVS_READDATA_O <= '0;
        endcase
      end
    end
  end

  assign AVS_WAITREQUEST_O = wait_q;

  // Control register
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      term_q <= CTRL_TERM_RST;
    else if (CLK_EN_I && AVS_WRITE_I && !wait_q && AVS_ADDRESS_I == OFS_CTRL && AVS_BYTEENABLE_I[0])
      term_q <= AVS_WRITEDATA_I[CTRL_TERM_BIT];
  end

  // Overlap flag: write one clears, a new overlap in the same cycle wins
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      ovl_q <= 1'b0;
    else if (CLK_EN_I)
    begin
      if (go && (cmd == CMD_RD || cmd == CMD_WR) && bst_q != B_IDLE)
        ovl_q <= 1'b1;
      else if (AVS_WRITE_I && !wait_q && AVS_ADDRESS_I == OFS_STATUS && AVS_BYTEENABLE_I[0] &&
               AVS_WRITEDATA_I[ST_OVL_BIT])
        ovl_q <= 1'b0;
    end
  end

  // Checks
  property p_deselect;
    CLK_EN_I && rise && cmd_cs_n && !close_ap |=> bank_q == $past(bank_q);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected edge changed banks");

  property p_nop;
    CLK_EN_I && go && cmd == CMD_NOP && !close_ap |=> $stable(bank_q);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed banks");

  property p_act;
    CLK_EN_I && go && cmd == CMD_ACT |=> bank_q[$past(cmd_ba)] && last_row_q == $past(cmd_addr);
  endproperty
  a_act: assert property (p_act) else $error("activate did not open row");

  property p_pre_all;
    CLK_EN_I && go && cmd == CMD_PRE && cmd_addr[10] |=> bank_q == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_mode0;
    CLK_EN_I && go && cmd == CMD_MODE && cmd_ba == 3'h0 |=> mr_q[0] == $past(cmd_addr);
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode set op-code not stored");

  property p_susp;
    CLK_EN_I && rise && !cmd_cke |=> susp_q ##1 SUSPENDED_O || !$past(CLK_EN_I);
  endproperty
  a_susp: assert property (p_susp) else $error("gate low did not suspend");

  property p_frozen;
    CLK_EN_I && susp_q && !rise |=> $stable(beat_q) && $stable(lat_q) && $stable(bst_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("burst moved while suspended");

  property p_rdlat_load;
    CLK_EN_I && go && cmd == CMD_RD && bst_q == B_IDLE |=> lat_q == $past(rd_lat) - 5'h01 && bst_q == B_WAIT;
  endproperty
  a_rdlat_load: assert property (p_rdlat_load) else $error("read latency load wrong");

  property p_chop;
    CLK_EN_I && go && cmd == CMD_RD && bst_q == B_IDLE && mr_q[0][MODE0_BL_LO +: 2] == BL_PERCMD |=>
      acc_chop_q == !$past(cmd_addr[12]);
  endproperty
  a_chop: assert property (p_chop) else $error("per-command chop ignored");

  property p_wmask;
    WMASK_EN_O |-> !TERM_EN_O && WR_WINDOW_O;
  endproperty
  a_wmask: assert property (p_wmask) else $error("mask active with termination");

  property p_strobe;
    STROBE_OE_O |-> RD_VALID_O && !WR_WINDOW_O;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe driven outside read");

  c_act:     cover property (go && cmd == CMD_ACT);
  c_read:    cover property (RD_VALID_O && BEAT_COL_O == 3'h7);
  c_write:   cover property (WR_WINDOW_O && WMASK_EN_O);
  c_suspend: cover property (SUSPENDED_O && BANK_OPEN_O == '0);
endmodule : dram_cmd_decoder

// File: sim/ctrl_model.sv
// Memory controller model: free-running link clock, clock gate and command pins
`timescale 1ns/100ps
module ctrl_model
  import dram_cmd_pkg::*;
(
  // Link clock
  output logic              link_clk_o,
  output logic              link_clk_n_o,
  // Command pins
  output logic              gate_o,
  output logic              cs_n_o,
  output logic              ras_n_o,
  output logic              cas_n_o,
  output logic              we_n_o,
  output logic [BANK_W-1:0] bank_o,
  output logic [ROW_W-1:0]  addr_o
);
  realtime t_cmd;

  // Link clock runs continuously; odd start offset keeps it unrelated to the system clock
  initial
  begin
    link_clk_o = 1'b0;
    gate_o = 1'b1;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = 3'h7;
    bank_o = 3'h0;
    addr_o = 14'h0000;
    #3.3;
    forever #32 link_clk_o = ~link_clk_o;
  end

  // Complement clock
  assign link_clk_n_o = ~link_clk_o;

  // One command around a rising crossing; pins move on falling edges only
  task automatic issue(input logic cs_n, input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
    @(negedge link_clk_o);
    cs_n_o <= cs_n;
    {ras_n_o, cas_n_o, we_n_o} <= rcw;
    bank_o <= ba;
    addr_o <= a;
    @(posedge link_clk_o);
    t_cmd = $realtime;
    @(negedge link_clk_o);
    // Deselected lines show the inverse, so a stale capture cannot pass
    cs_n_o <= 1'b1;
    {ras_n_o, cas_n_o, we_n_o} <= ~rcw;
    bank_o <= ~ba;
    addr_o <= ~a;
  endtask : issue

  // Gate changes only when the bench has closed every bank first
  task automatic set_gate(input logic v);
    @(negedge link_clk_o);
    gate_o <= v;
  endtask : set_gate
endmodule : ctrl_model

// File: sim/testbench.sv
// Self-checking bench for the DRAM command decoder
`timescale 1ns/100ps
module testbench
  import dram_cmd_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, avs_rd = 1'b0, avs_wr = 1'b0;
  logic [7:0] avs_addr = 8'h00;
  logic [31:0] avs_wdata = 32'h0, q;
  logic lk, lk_n, gate, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic RD_VALID_O, WR_WINDOW_O, STROBE_O, STROBE_OE_O, WMASK_EN_O, TERM_EN_O, SUSPENDED_O, PD_FAST_EXIT_O;
  logic [2:0] BEAT_COL_O;
  logic [7:0] BANK_OPEN_O;
  logic [31:0] AVS_READDATA_O;
  logic AVS_WAITREQUEST_O;
  logic [2:0] beat_q[$];
  logic stb_q[$];
  int bad_count = 0, check_count = 0, oe_lo, mask_hi, cyc = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  ctrl_model u_ctrl (.link_clk_o(lk), .link_clk_n_o(lk_n), .gate_o(gate), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(ba), .addr_o(addr));

  dram_cmd_decoder DUT (.REF_CLK_I(clk), .RST_I(rst), .CLK_EN_I(1'b1), .LINK_CLK_I(lk), .LINK_CLK_N_I(lk_n),
    .CLOCK_GATE_I(gate), .CHIP_SEL_N_I(cs_n), .ROW_STROBE_N_I(ras_n), .COL_STROBE_N_I(cas_n),
    .WRITE_SEL_N_I(we_n), .BANK_SEL_I(ba), .ADDR_I(addr), .RD_VALID_O(RD_VALID_O), .WR_WINDOW_O(WR_WINDOW_O),
    .BEAT_COL_O(BEAT_COL_O), .STROBE_O(STROBE_O), .STROBE_OE_O(STROBE_OE_O), .WMASK_EN_O(WMASK_EN_O),
    .TERM_EN_O(TERM_EN_O), .SUSPENDED_O(SUSPENDED_O), .PD_FAST_EXIT_O(PD_FAST_EXIT_O),
    .BANK_OPEN_O(BANK_OPEN_O), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr),
    .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));

  // One entry per read beat; the sampled value is the one before the edge, so no race
  always @(posedge clk)
  begin
    if (RD_VALID_O === 1'b1 && (beat_q.size() == 0 || BEAT_COL_O !== beat_q[$]))
    begin
      beat_q.push_back(BEAT_COL_O);
      stb_q.push_back(STROBE_O);
    end
    if (RD_VALID_O === 1'b1 && STROBE_OE_O !== 1'b1) oe_lo++;
    if (WR_WINDOW_O === 1'b1 && WMASK_EN_O === 1'b1) mask_hi++;
  end

  // Hang guard, well above the roughly 2000 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Avalon-MM transfer: held until waitrequest is seen low at a rising edge
  task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_addr <= a;
    avs_rd <= ~wr;
    avs_wr <= wr;
    avs_wdata <= d;
    do @(posedge clk); while (AVS_WAITREQUEST_O !== 1'b0);
    q = AVS_READDATA_O;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask : avs

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    check(q === e, "register read");
  endtask : reg_chk

  // Command followed by time for the sync pipeline to settle
  task automatic cmd(input logic c, input logic [2:0] rcw, input logic [2:0] b, input logic [13:0] a);
    u_ctrl.issue(c, rcw, b, a);
    repeat (4) @(posedge clk);
  endtask : cmd

  function automatic logic [2:0] beat_of(input logic [2:0] c, input int b, input logic il);
    logic [2:0] k;
    k = b[2:0];
    if (il) return c ^ k;
    return {c[2] ^ k[2], c[1:0] + k[1:0]};
  endfunction : beat_of

  // Column access to bank 3; judges latency, length, beat order, strobe and mask
  task automatic burst(input logic wr, input logic [2:0] c, input logic chop_n, input logic ac, input int nb,
                       input int lat, input logic il, input logic term);
    int n;
    realtime t0;
    beat_q.delete();
    stb_q.delete();
    oe_lo = 0;
    mask_hi = 0;
    u_ctrl.issue(1'b0, {2'b10, ~wr}, 3'h3, {1'b0, chop_n, 1'b0, ac, 7'h00, c});
    n = 0;
    while ((wr ? WR_WINDOW_O : RD_VALID_O) !== 1'b1 && n < 4000) begin @(posedge clk); n++; end
    t0 = $realtime - u_ctrl.t_cmd;
    check(t0 > lat * 64.0 && t0 <= lat * 64.0 + 48.0, "burst start");
    t0 = $realtime;
    n = 0;
    while ((wr ? WR_WINDOW_O : RD_VALID_O) !== 1'b0 && n < 4000) begin @(posedge clk); n++; end
    t0 = $realtime - t0;
    check(t0 > nb * 32.0 - 8.0 && t0 < nb * 32.0 + 8.0, "burst length");
    if (wr) check((mask_hi > 0) === ~term, "write mask");
    else
    begin
      check(beat_q.size() == nb && oe_lo == 0, "beat count");
      for (int i = 0; i < beat_q.size(); i++)
      begin
        check(beat_q[i] === beat_of(c, i, il), "beat order");
        check(stb_q[i] === (i[0] ? 1'b0 : 1'b1), "strobe");
      end
    end
    repeat (8) @(posedge clk);
  endtask : burst

  task automatic t_regs;
    reg_chk(OFS_CTRL, 32'h0);
    reg_chk(OFS_STATUS, 32'h0);
    reg_chk(OFS_MODE0, 32'h0);
    reg_chk(8'h40, 32'h0);
    avs(1'b1, OFS_CTRL, 32'h1);
    reg_chk(OFS_CTRL, 32'h1);
    check(TERM_EN_O === 1'b1, "termination enable");
    avs(1'b1, OFS_CTRL, 32'h0);
    avs(1'b1, 8'h40, 32'hffff_ffff);
    reg_chk(8'h40, 32'h0);
  endtask : t_regs

  // Write CAS 6, read CAS 6, then added-delay codes 0 to 2
  task automatic t_mode;
    logic [4:0] ae;
    cmd(1'b0, 3'h0, 3'h2, 14'h0008);
    cmd(1'b0, 3'h0, 3'h0, 14'h1021);
    reg_chk(OFS_MODE0, 32'h0000_1021);
    check(PD_FAST_EXIT_O === 1'b1, "fast exit");
    for (int ad = 0; ad < 3; ad++)
    begin
      cmd(1'b0, 3'h0, 3'h1, 14'(ad << 3));
      ae = (ad == 0) ? 5'h00 : 5'h06 - 5'(ad);
      reg_chk(OFS_LAT, {19'h0, ae + 5'h06, 3'h0, ae + 5'h06});
    end
  endtask : t_mode

  task automatic t_banks;
    cmd(1'b1, 3'h3, 3'h5, 14'h0000);
    check(BANK_OPEN_O === 8'h00, "deselected command");
    cmd(1'b0, 3'h3, 3'h3, 14'h2abc);
    check(BANK_OPEN_O === 8'h08, "activate");
    reg_chk(OFS_LASTACT, 32'h0003_2abc);
    cmd(1'b0, 3'h7, 3'h3, 14'h0000);
    reg_chk(OFS_BANKS, 32'h0000_0008);
    cmd(1'b0, 3'h1, 3'h0, 14'h0000);
    check(BANK_OPEN_O === 8'h08, "refresh changed banks");
  endtask : t_banks

  // Bank 3 stays open before each access; read and write latency are both 10
  task automatic t_bursts;
    burst(1'b0, 3'h5, 1'b1, 1'b0, 8, 10, 1'b0, 1'b0);
    burst(1'b0, 3'h5, 1'b0, 1'b0, 4, 10, 1'b0, 1'b0);
    burst(1'b1, 3'h2, 1'b1, 1'b0, 8, 10, 1'b0, 1'b0);
    avs(1'b1, OFS_CTRL, 32'h1);
    burst(1'b1, 3'h2, 1'b0, 1'b0, 4, 10, 1'b0, 1'b1);
    avs(1'b1, OFS_CTRL, 32'h0);
    cmd(1'b0, 3'h0, 3'h0, 14'h102a);
    burst(1'b0, 3'h5, 1'b1, 1'b1, 4, 10, 1'b1, 1'b0);
    check(BANK_OPEN_O === 8'h00, "auto close");
    cmd(1'b0, 3'h0, 3'h0, 14'h1028);
    cmd(1'b0, 3'h3, 3'h3, 14'h0001);
    burst(1'b0, 3'h6, 1'b0, 1'b0, 8, 10, 1'b1, 1'b0);
  endtask : t_bursts

  // A second read while one is pending is dropped, flagged, and the flag clears by writing one
  task automatic t_ovl;
    u_ctrl.issue(1'b0, 3'h5, 3'h3, 14'h1000);
    u_ctrl.issue(1'b0, 3'h5, 3'h3, 14'h1000);
    reg_chk(OFS_STATUS, 32'h0000_000c);
    repeat (200) @(posedge clk);
    reg_chk(OFS_STATUS, 32'h0000_0008);
    avs(1'b1, OFS_STATUS, 32'h8);
    reg_chk(OFS_STATUS, 32'h0000_0000);
  endtask : t_ovl

  task automatic t_close;
    cmd(1'b0, 3'h3, 3'h1, 14'h0010);
    cmd(1'b0, 3'h3, 3'h2, 14'h0020);
    check(BANK_OPEN_O === 8'h0e, "three open");
    cmd(1'b0, 3'h2, 3'h1, 14'h0000);
    check(BANK_OPEN_O === 8'h0c, "single close");
    cmd(1'b0, 3'h2, 3'h6, 14'h0400);
    check(BANK_OPEN_O === 8'h00, "all close");
  endtask : t_close

  // Gate taken low only with every bank idle
  task automatic t_gate;
    u_ctrl.set_gate(1'b0);
    repeat (30) @(posedge clk);
    check(SUSPENDED_O === 1'b1, "suspend");
    reg_chk(OFS_STATUS, 32'h0000_0003);
    u_ctrl.set_gate(1'b1);
    repeat (30) @(posedge clk);
    check(SUSPENDED_O === 1'b0, "resume");
  endtask : t_gate

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_mode();
    t_banks();
    t_bursts();
    t_ovl();
    t_close();
    t_gate();
    complete_run();
  end
endmodule : testbench
